//--- rtl/port_mux_pkg.sv
// port function mux package: function selects, pin roles, widths, reset values
// assumes a single 250 MHz clock domain and synchronous active-low reset
package port_mux_pkg;

   // ****************************************************************
   // widths
   // ****************************************************************
   localparam int DATA_W = 8;
   localparam int PORT_W = 8;
   localparam int PORTD_W = 3;
   localparam int SLEW_W = 4;

   // ****************************************************************
   // pin function codes, fixed from non-volatile configuration
   // ****************************************************************
   typedef enum logic [1:0] {
      FN_DIRECT_IO = 2'b00,
      FN_CELL_OUT = 2'b01,
      FN_PLD_IN = 2'b10,
      FN_CHIP_SEL = 2'b11
   } pin_fn_e;

   // ****************************************************************
   // third port alternate-role bit positions
   // ****************************************************************
   localparam int POS_TMS = 0;
   localparam int POS_TCK = 1;
   localparam int POS_IO_SEL = 2;
   localparam int POS_STATUS = 3;
   localparam int POS_ERROR = 4;
   localparam int POS_TDI = 5;
   localparam int POS_TDO = 6;

   // ****************************************************************
   // fourth port alternate-role bit positions
   // ****************************************************************
   localparam int POS_ADDR16 = 0;
   localparam int POS_PLD_SHARED_CLOCK_IN = 1;
   localparam int POS_FLASH_CS = 2;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] RST_PORT = 8'h00;
   localparam logic [3:0] RST_SLEW = 4'h0;
   localparam logic [7:0] RST_OD = 8'h00;

   // one pin's next output drive and enable
   function automatic logic [1:0] drive_pair(input pin_fn_e fn, input logic dir_val, input logic dir_oe,
                                            input logic cell_val, input logic cell_oe,
                                            input logic open_drain);
      logic val;
      logic oe;
      val = 1'b0;
      oe = 1'b0;
      unique case (fn)
         FN_DIRECT_IO: begin
            val = dir_val;
            oe = dir_oe;
         end
         FN_CELL_OUT, FN_CHIP_SEL: begin
            val = cell_val;
            oe = cell_oe;
         end
         FN_PLD_IN: begin
            val = 1'b0;
            oe = 1'b0;
         end
      endcase
      // open drain drives only low
      if (open_drain && oe) begin
         oe = ~val;
         val = 1'b0;
      end
      return {val, oe};
   endfunction : drive_pair

endpackage : port_mux_pkg

//--- rtl/port_mux_if.sv
// carrier for the per-port drive control between the top and its pin slice
// assumes both ends in the i_mclk domain
`timescale 1ns/1ps
interface port_mux_if;
   import port_mux_pkg::*;
   logic [PORT_W-1:0] dir_val;
   logic [PORT_W-1:0] dir_oe;
   logic [PORT_W-1:0] cell_val;
   logic [PORT_W-1:0] cell_oe;
   logic [PORT_W-1:0] open_drain;
   pin_fn_e fn [PORT_W];
   logic [PORT_W-1:0] pin_out;
   logic [PORT_W-1:0] pin_oe;
   modport ctrl (output dir_val, dir_oe, cell_val, cell_oe, open_drain, fn, input pin_out, pin_oe);
   modport slice (input dir_val, dir_oe, cell_val, cell_oe, open_drain, fn, output pin_out, pin_oe);
endinterface : port_mux_if

//--- rtl/port_pin_slice.sv
// pin slice: per-pin function mux and drive style for one eight-bit port
// assumes function codes are static between resets
`timescale 1ns/1ps
module port_pin_slice
   import port_mux_pkg::*;
#(
   parameter int WIDTH = PORT_W
) (
   port_mux_if.slice bus
);

   // ****************************************************************
   // per-pin drive selection
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_pin
         logic [1:0] pair;
         // function mux then open drain conversion
         always_comb begin
            pair = drive_pair(bus.fn[g], bus.dir_val[g], bus.dir_oe[g], bus.cell_val[g], bus.cell_oe[g],
                              bus.open_drain[g]);
         end
         assign bus.pin_out[g] = pair[1];
         assign bus.pin_oe[g] = pair[0];
      end
   endgenerate

endmodule : port_pin_slice

//--- rtl/port_pin_function_mux.sv
// port function mux: data byte lane, two eight-bit ports, alternate programming
// roles and a three-pin port with chip selects, shared clock and flash select
// assumes pin inputs synchronous to i_mclk; function codes from configuration
// Operation
// RULE1: data port carries processor data bits 8-15
// RULE2: second port pins: direct, cell output, input
// RULE3: processor writes and reads back direct pins
// RULE4: second port low four pins select slew
// RULE5: third port pins: direct, cell output, input
// RULE6: third port 0,1,5,6 become scan pins
// RULE7: third port 3,4 give status, error outputs
// RULE8: third port bit 3 drives ready/busy
// RULE9: third port general pins push-pull or open-drain
// RULE10: scan pins share pins with other functions
// RULE11: fourth port: direct, direct input, chip select
// RULE12: fourth port bit 1 shared logic clock
// RULE13: fourth port bit 2 flash select, high disables
// RULE14: system may route io select to bit 2
// RULE15: system may route address 16 to bit 0
// RULE16: processor drives read strobe on control one
// RULE17: processor drives byte select on control two
// RULE18: functions fixed; only drive options runtime
`timescale 1ns/1ps
module port_pin_function_mux
   import port_mux_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // fixed function configuration
   input wire pin_fn_e i_second_fn [PORT_W],
   input wire pin_fn_e i_third_fn [PORT_W],
   input wire pin_fn_e i_fourth_fn [PORTD_W],
   input wire logic i_scan_en,
   input wire logic i_enh_scan_en,
   input wire logic i_rdy_busy_en,
   input wire logic i_pld_shared_clock_in_en,
   input wire logic i_flash_cs_en,
   // runtime drive options
   input wire logic [SLEW_W-1:0] i_second_slew,
   input wire logic [PORT_W-1:0] i_third_open_drain,
   // processor data path and control inputs
   input wire logic [DATA_W-1:0] i_core_rd_data,
   input wire logic i_core_rd_oe,
   input wire logic i_ctrl_input_one,
   input wire logic i_ctrl_input_two,
   output logic [DATA_W-1:0] o_core_wr_data,
   output logic o_read_strobe,
   output logic o_byte_mem_select,
   // direct io registers
   input wire logic [PORT_W-1:0] i_second_dir_val,
   input wire logic [PORT_W-1:0] i_second_dir_oe,
   input wire logic [PORT_W-1:0] i_third_dir_val,
   input wire logic [PORT_W-1:0] i_third_dir_oe,
   input wire logic [PORTD_W-1:0] i_fourth_dir_val,
   input wire logic [PORTD_W-1:0] i_fourth_dir_oe,
   output logic [PORT_W-1:0] o_second_readback,
   output logic [PORT_W-1:0] o_third_readback,
   output logic [PORTD_W-1:0] o_fourth_readback,
   // logic array side
   input wire logic [PORT_W-1:0] i_output_cell_group_one,
   input wire logic [PORT_W-1:0] i_output_cell_group_two,
   input wire logic [PORT_W-1:0] i_cell_oe_second,
   input wire logic [PORT_W-1:0] i_cell_oe_third,
   input wire logic [PORTD_W-1:0] i_chip_sel,
   input wire logic i_scan_tdo,
   input wire logic i_prog_status,
   input wire logic i_prog_error,
   input wire logic i_flash_ready,
   output logic [PORT_W-1:0] o_pld_in_second,
   output logic [PORT_W-1:0] o_pld_in_third,
   output logic [PORTD_W-1:0] o_pld_in_fourth,
   output logic o_scan_tms,
   output logic o_scan_tck,
   output logic o_scan_tdi,
   output logic o_pld_shared_clock_in,
   output logic o_flash_enable,
   // pins
   input wire logic [DATA_W-1:0] i_data_port_pins,
   output logic [DATA_W-1:0] o_data_port_pins,
   output logic [DATA_W-1:0] o_data_port_pins_oe,
   input wire logic [PORT_W-1:0] i_second_port_pins,
   output logic [PORT_W-1:0] o_second_port_pins,
   output logic [PORT_W-1:0] o_second_port_pins_oe,
   output logic [SLEW_W-1:0] o_second_port_fast_slew,
   input wire logic [PORT_W-1:0] i_third_port_pins,
   output logic [PORT_W-1:0] o_third_port_pins,
   output logic [PORT_W-1:0] o_third_port_pins_oe,
   input wire logic [PORTD_W-1:0] i_fourth_port_pins,
   output logic [PORTD_W-1:0] o_fourth_port_pins,
   output logic [PORTD_W-1:0] o_fourth_port_pins_oe
);

   // ****************************************************************
   // second and third port slices
   // ****************************************************************
   port_mux_if second_if ();
   port_mux_if third_if ();

   // second port: cells from group one, no open drain
   always_comb begin
      second_if.dir_val = i_second_dir_val; // [RULE3]
      second_if.dir_oe = i_second_dir_oe;
      second_if.cell_val = i_output_cell_group_one;
      second_if.cell_oe = i_cell_oe_second;
      second_if.open_drain = RST_OD;
      second_if.fn = i_second_fn; // [RULE2] [RULE18]
   end

   // third port: cells from group two, runtime open drain on general io
   always_comb begin
      third_if.dir_val = i_third_dir_val; // [RULE3]
      third_if.dir_oe = i_third_dir_oe;
      third_if.cell_val = i_output_cell_group_two;
      third_if.cell_oe = i_cell_oe_third;
      third_if.open_drain = i_third_open_drain; // [RULE9]
      third_if.fn = i_third_fn; // [RULE5] [RULE18]
   end

   port_pin_slice #(.WIDTH(PORT_W)) u_second (.bus(second_if.slice));
   port_pin_slice #(.WIDTH(PORT_W)) u_third (.bus(third_if.slice));

   // ****************************************************************
   // next-state computation
   // ****************************************************************
   logic [DATA_W-1:0] data_out_ff, nxt_data_out, data_oe_ff, nxt_data_oe, data_in_ff, nxt_data_in;
   logic [PORT_W-1:0] b_out_ff, nxt_b_out, b_oe_ff, nxt_b_oe, b_rb_ff, nxt_b_rb, b_pld_ff, nxt_b_pld;
   logic [PORT_W-1:0] c_out_ff, nxt_c_out, c_oe_ff, nxt_c_oe, c_rb_ff, nxt_c_rb, c_pld_ff, nxt_c_pld;
   logic [PORTD_W-1:0] d_out_ff, nxt_d_out, d_oe_ff, nxt_d_oe, d_rb_ff, nxt_d_rb, d_pld_ff, nxt_d_pld;
   logic [SLEW_W-1:0] slew_ff, nxt_slew;
   logic [2:0] scan_ff, nxt_scan;
   logic [1:0] ctrl_ff, nxt_ctrl;
   logic pld_shared_clock_in_ff, nxt_pld_shared_clock_in, flash_en_ff, nxt_flash_en;

   // data lane, second port and control strobes
   always_comb begin
      nxt_data_out = i_core_rd_data; // [RULE1]
      nxt_data_oe = {DATA_W{i_core_rd_oe}};
      nxt_data_in = i_data_port_pins; // [RULE1]
      nxt_b_out = second_if.pin_out; // [RULE2]
      nxt_b_oe = second_if.pin_oe;
      nxt_b_rb = i_second_port_pins; // [RULE3]
      nxt_b_pld = i_second_port_pins;
      nxt_slew = i_second_slew; // [RULE4]
      nxt_ctrl = {i_ctrl_input_two, i_ctrl_input_one}; // [RULE16] [RULE17]
   end

   // third port with alternate programming roles overriding the slice
   always_comb begin
      nxt_c_out = third_if.pin_out; // [RULE10]
      nxt_c_oe = third_if.pin_oe;
      nxt_c_rb = i_third_port_pins;
      nxt_c_pld = i_third_port_pins; // [RULE14]
      nxt_scan = {i_third_port_pins[POS_TDI], i_third_port_pins[POS_TCK], i_third_port_pins[POS_TMS]};
      if (i_scan_en) begin
         nxt_c_oe[POS_TMS] = 1'b0; // [RULE6]
         nxt_c_oe[POS_TCK] = 1'b0;
         nxt_c_oe[POS_TDI] = 1'b0;
         nxt_c_out[POS_TDO] = i_scan_tdo; // [RULE6]
         nxt_c_oe[POS_TDO] = 1'b1;
      end else begin
         nxt_scan = 3'h0;
      end
      if (i_scan_en && i_enh_scan_en) begin
         nxt_c_out[POS_STATUS] = i_prog_status; // [RULE7]
         nxt_c_oe[POS_STATUS] = 1'b1;
         nxt_c_out[POS_ERROR] = i_prog_error; // [RULE7]
         nxt_c_oe[POS_ERROR] = 1'b1;
      end else if (i_rdy_busy_en) begin
         nxt_c_out[POS_STATUS] = i_flash_ready; // [RULE8]
         nxt_c_oe[POS_STATUS] = 1'b1;
      end
   end

   // fourth port: direct, direct pld input, chip select, clock, flash select
   always_comb begin
      nxt_d_rb = i_fourth_port_pins;
      nxt_d_pld = i_fourth_port_pins; // [RULE15]
      for (int k = 0; k < PORTD_W; k++) begin
         unique case (i_fourth_fn[k])
            FN_DIRECT_IO: begin
               nxt_d_out[k] = i_fourth_dir_val[k]; // [RULE11]
               nxt_d_oe[k] = i_fourth_dir_oe[k];
            end
            FN_CHIP_SEL: begin
               nxt_d_out[k] = i_chip_sel[k]; // [RULE11]
               nxt_d_oe[k] = 1'b1;
            end
            FN_CELL_OUT, FN_PLD_IN: begin
               nxt_d_out[k] = 1'b0; // no output cell on this port: input only
               nxt_d_oe[k] = 1'b0;
            end
         endcase
      end
      nxt_pld_shared_clock_in = 1'b0;
      if (i_pld_shared_clock_in_en) begin
         nxt_pld_shared_clock_in = i_fourth_port_pins[POS_PLD_SHARED_CLOCK_IN]; // [RULE12]
         nxt_d_oe[POS_PLD_SHARED_CLOCK_IN] = 1'b0;
      end
      nxt_flash_en = 1'b1;
      if (i_flash_cs_en) begin
         nxt_flash_en = ~i_fourth_port_pins[POS_FLASH_CS]; // [RULE13]
         nxt_d_oe[POS_FLASH_CS] = 1'b0;
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         data_out_ff <= RST_PORT;
         data_oe_ff <= RST_PORT;
         data_in_ff <= RST_PORT;
         b_out_ff <= RST_PORT;
         b_oe_ff <= RST_PORT;
         b_rb_ff <= RST_PORT;
         b_pld_ff <= RST_PORT;
         c_out_ff <= RST_PORT;
         c_oe_ff <= RST_PORT;
         c_rb_ff <= RST_PORT;
         c_pld_ff <= RST_PORT;
         d_out_ff <= 3'h0;
         d_oe_ff <= 3'h0;
         d_rb_ff <= 3'h0;
         d_pld_ff <= 3'h0;
         slew_ff <= RST_SLEW;
         scan_ff <= 3'h0;
         ctrl_ff <= 2'h3;
         pld_shared_clock_in_ff <= 1'b0;
         flash_en_ff <= 1'b0;
      end else begin
         data_out_ff <= nxt_data_out;
         data_oe_ff <= nxt_data_oe;
         data_in_ff <= nxt_data_in;
         b_out_ff <= nxt_b_out;
         b_oe_ff <= nxt_b_oe;
         b_rb_ff <= nxt_b_rb;
         b_pld_ff <= nxt_b_pld;
         c_out_ff <= nxt_c_out;
         c_oe_ff <= nxt_c_oe;
         c_rb_ff <= nxt_c_rb;
         c_pld_ff <= nxt_c_pld;
         d_out_ff <= nxt_d_out;
         d_oe_ff <= nxt_d_oe;
         d_rb_ff <= nxt_d_rb;
         d_pld_ff <= nxt_d_pld;
         slew_ff <= nxt_slew;
         scan_ff <= nxt_scan;
         ctrl_ff <= nxt_ctrl;
         pld_shared_clock_in_ff <= nxt_pld_shared_clock_in;
         flash_en_ff <= nxt_flash_en;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign o_data_port_pins = data_out_ff;
   assign o_data_port_pins_oe = data_oe_ff;
   assign o_core_wr_data = data_in_ff;
   assign o_second_port_pins = b_out_ff;
   assign o_second_port_pins_oe = b_oe_ff;
   assign o_second_port_fast_slew = slew_ff;
   assign o_second_readback = b_rb_ff;
   assign o_pld_in_second = b_pld_ff;
   assign o_third_port_pins = c_out_ff;
   assign o_third_port_pins_oe = c_oe_ff;
   assign o_third_readback = c_rb_ff;
   assign o_pld_in_third = c_pld_ff;
   assign o_fourth_port_pins = d_out_ff;
   assign o_fourth_port_pins_oe = d_oe_ff;
   assign o_fourth_readback = d_rb_ff;
   assign o_pld_in_fourth = d_pld_ff;
   assign o_scan_tms = scan_ff[0];
   assign o_scan_tck = scan_ff[1];
   assign o_scan_tdi = scan_ff[2];
   assign o_read_strobe = ctrl_ff[0];
   assign o_byte_mem_select = ctrl_ff[1];
   assign o_pld_shared_clock_in = pld_shared_clock_in_ff;
   assign o_flash_enable = flash_en_ff;

endmodule : port_pin_function_mux

//--- tb/port_mux_monitor.sv
// checker: registered pass-through relations at the mux top ports
// assumes binding into port_pin_function_mux, one i_mclk domain
`timescale 1ns/1ps
module port_mux_monitor (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic [7:0] i_data_port_pins,
   input wire logic [7:0] o_core_wr_data,
   input wire logic [7:0] i_core_rd_data,
   input wire logic i_core_rd_oe,
   input wire logic [7:0] o_data_port_pins,
   input wire logic [7:0] o_data_port_pins_oe,
   input wire logic [3:0] i_second_slew,
   input wire logic [3:0] o_second_port_fast_slew,
   input wire logic [7:0] i_third_port_pins,
   input wire logic [7:0] o_third_readback,
   input wire logic [7:0] o_third_port_pins,
   input wire logic [7:0] o_third_port_pins_oe,
   input wire logic [2:0] i_fourth_port_pins,
   input wire logic i_flash_cs_en,
   input wire logic o_flash_enable,
   input wire logic i_pld_shared_clock_in_en,
   input wire logic o_pld_shared_clock_in,
   input wire logic i_scan_en,
   input wire logic i_scan_tdo,
   input wire logic o_scan_tms
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   // previous edge was out of reset
   sequence live;
      $past(i_reset_n);
   endsequence
   // scan roles were on at the previous edge
   sequence scan_live;
      live ##0 $past(i_scan_en);
   endsequence
   data_lane_a: assert property (live |-> o_core_wr_data == $past(i_data_port_pins))
      else $error("data lane sample wrong");
   rd_drive_a: assert property (live |-> o_data_port_pins_oe == {8{$past(i_core_rd_oe)}})
      else $error("data lane enable wrong");
   rd_value_a: assert property (live ##0 $past(i_core_rd_oe) |-> o_data_port_pins == $past(i_core_rd_data))
      else $error("data lane drive wrong");
   slew_pass_a: assert property (live |-> o_second_port_fast_slew == $past(i_second_slew))
      else $error("slew select wrong");
   pin_readback_a: assert property (live |-> o_third_readback == $past(i_third_port_pins))
      else $error("readback wrong");
   flash_gate_a: assert property (live |->
      o_flash_enable == ($past(i_flash_cs_en) ? ~$past(i_fourth_port_pins[2]) : 1'b1))
      else $error("flash enable wrong");
   clk_route_a: assert property (live |->
      o_pld_shared_clock_in == ($past(i_pld_shared_clock_in_en) & $past(i_fourth_port_pins[1])))
      else $error("shared clock wrong");
   scan_tdo_a: assert property (scan_live |->
      o_third_port_pins[6] == $past(i_scan_tdo) && o_third_port_pins_oe[6])
      else $error("scan out wrong");
   scan_tms_a: assert property (live |-> o_scan_tms == ($past(i_scan_en) & $past(i_third_port_pins[0])))
      else $error("scan mode input wrong");
endmodule : port_mux_monitor
bind port_pin_function_mux port_mux_monitor mon (.*);

//--- tb/dsp_port_model.sv
// processor external port: strobes and data byte toward the mux
// assumes bench resolves the shared data wire from the device enable alone
`timescale 1ns/1ps
module dsp_port_model (
   input wire logic i_mclk,
   input wire logic i_req,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   output logic o_rd_n,
   output logic o_bsel_n,
   output logic [7:0] o_pins
);
   initial begin
      o_rd_n = 1'b1;
      o_bsel_n = 1'b1;
      o_pins = 8'h00;
   end
   // strobes and bus change just after the edge; released bus toggles
   always @(posedge i_mclk) begin
      o_rd_n <= ~(i_req & ~i_wr);
      o_bsel_n <= ~i_req;
      o_pins <= (i_req & i_wr) ? i_wdata : ~o_pins;
   end
endmodule : dsp_port_model

//--- tb/port_pin_function_mux_bench.sv
// bench: directed scenarios per pin function and alternate role
// assumes port_mux_pkg compiled first and the monitor bound
`timescale 1ns/1ps
module port_pin_function_mux_bench;
   import port_mux_pkg::*;
   logic i_mclk, i_reset_n, i_scan_en, i_enh_scan_en, i_rdy_busy_en, i_pld_shared_clock_in_en, i_flash_cs_en, i_core_rd_oe;
   logic i_ctrl_input_one, i_ctrl_input_two, i_scan_tdo, i_prog_status, i_prog_error, i_flash_ready, m_req, m_wr;
   logic o_read_strobe, o_byte_mem_select, o_scan_tms, o_scan_tck, o_scan_tdi, o_pld_shared_clock_in, o_flash_enable;
   logic [7:0] i_core_rd_data, o_core_wr_data, i_second_dir_val, i_second_dir_oe, i_third_dir_val, i_third_dir_oe;
   logic [7:0] o_second_readback, o_third_readback, i_output_cell_group_one, i_output_cell_group_two, m_wdata, m_pins;
   logic [7:0] i_cell_oe_second, i_cell_oe_third, o_pld_in_second, o_pld_in_third, i_data_port_pins, o_data_port_pins;
   logic [7:0] o_data_port_pins_oe, i_second_port_pins, o_second_port_pins, o_second_port_pins_oe, i_third_port_pins;
   logic [7:0] o_third_port_pins, o_third_port_pins_oe, i_third_open_drain;
   logic [3:0] i_second_slew, o_second_port_fast_slew;
   logic [2:0] i_fourth_dir_val, i_fourth_dir_oe, o_fourth_readback, i_chip_sel, o_pld_in_fourth;
   logic [2:0] i_fourth_port_pins, o_fourth_port_pins, o_fourth_port_pins_oe;
   pin_fn_e i_second_fn [PORT_W];
   pin_fn_e i_third_fn [PORT_W];
   pin_fn_e i_fourth_fn [PORTD_W];
   int n_mismatch = 0;
   int tests_run = 0;
   int cyc = 0;
   // shared data wire: device drive wins where enabled
   assign i_data_port_pins = (o_data_port_pins & o_data_port_pins_oe) | (m_pins & ~o_data_port_pins_oe);
   port_pin_function_mux dut (.*);
   dsp_port_model dsp (.i_mclk(i_mclk), .i_req(m_req), .i_wr(m_wr), .i_wdata(m_wdata),
                       .o_rd_n(i_ctrl_input_one), .o_bsel_n(i_ctrl_input_two), .o_pins(m_pins));
   initial begin
      i_mclk = 1'b0;
      forever #2 i_mclk = ~i_mclk;
   end
   // hang guard
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // let n edges sample, then look at settled outputs
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
      @(negedge i_mclk);
   endtask : tick
   task automatic set_fn(input pin_fn_e f);
      foreach (i_second_fn[k]) i_second_fn[k] <= f;
      foreach (i_third_fn[k]) i_third_fn[k] <= f;
      foreach (i_fourth_fn[k]) i_fourth_fn[k] <= f;
   endtask : set_fn
   task automatic t_data;
      @(posedge i_mclk);
      m_req <= 1'b1;
      m_wr <= 1'b1;
      m_wdata <= 8'ha5;
      tick(2);
      chk("wr_data", o_core_wr_data, 8'ha5);
      @(posedge i_mclk);
      m_wr <= 1'b0;
      i_core_rd_data <= 8'h3c;
      i_core_rd_oe <= 1'b1;
      tick(2);
      chk("rd_pins", o_data_port_pins, 8'h3c);
      chk("rd_oe", o_data_port_pins_oe, 8'hff);
      chk("rd_strobe", {7'h00, o_read_strobe}, 8'h00);
      chk("rd_bsel", {7'h00, o_byte_mem_select}, 8'h00);
      @(posedge i_mclk);
      m_req <= 1'b0;
      i_core_rd_oe <= 1'b0;
      tick(2);
      chk("rd_release", o_data_port_pins_oe, 8'h00);
   endtask : t_data
   task automatic t_funcs;
      logic [7:0] e;
      for (int f = 0; f < 4; f++) begin
         @(posedge i_mclk);
         set_fn(pin_fn_e'(f));
         tick(1);
         e = (f == 0) ? 8'h5a : (f == 2) ? 8'h00 : 8'hc3;
         chk("b_out", o_second_port_pins, e);
         chk("b_oe", o_second_port_pins_oe, (f == 0) ? 8'hff : (f == 2) ? 8'h00 : 8'h0f);
         e = (f == 0) ? 8'h96 : (f == 2) ? 8'h00 : 8'h3c;
         chk("c_out", o_third_port_pins, e);
         chk("c_oe", o_third_port_pins_oe, (f == 0) ? 8'hff : (f == 2) ? 8'h00 : 8'hf0);
         chk("d_out", {5'h00, o_fourth_port_pins}, (f == 0) ? 8'h05 : (f == 3) ? 8'h03 : 8'h00);
         chk("d_oe", {5'h00, o_fourth_port_pins_oe}, (f == 0 || f == 3) ? 8'h07 : 8'h00);
      end
   endtask : t_funcs
   task automatic t_read;
      @(posedge i_mclk);
      set_fn(FN_DIRECT_IO);
      i_second_port_pins <= 8'h81;
      i_third_port_pins <= 8'h7e; // io select high on bit 2
      i_fourth_port_pins <= 3'h5; // address 16 high on bit 0
      tick(1);
      chk("b_rb", o_second_readback, 8'h81);
      chk("c_rb", o_third_readback, 8'h7e);
      chk("d_rb", {5'h00, o_fourth_readback}, 8'h05);
      chk("b_in", o_pld_in_second, 8'h81);
      chk("c_in", o_pld_in_third, 8'h7e);
      chk("d_in", {5'h00, o_pld_in_fourth}, 8'h05);
   endtask : t_read
   task automatic t_slew;
      @(posedge i_mclk);
      i_second_slew <= 4'ha;
      tick(1);
      chk("slew_a", {4'h0, o_second_port_fast_slew}, 8'h0a);
      @(posedge i_mclk);
      i_second_slew <= 4'h5;
      tick(1);
      chk("slew_5", {4'h0, o_second_port_fast_slew}, 8'h05);
   endtask : t_slew
   task automatic t_scan;
      @(posedge i_mclk);
      i_third_dir_val <= 8'h04;
      i_third_port_pins <= 8'h21;
      i_scan_en <= 1'b1;
      i_scan_tdo <= 1'b1;
      tick(1);
      chk("scan_in", {5'h00, o_scan_tms, o_scan_tck, o_scan_tdi}, 8'h05);
      chk("scan_oe", o_third_port_pins_oe, 8'hdc);
      chk("scan_out", o_third_port_pins, 8'h44);
      @(posedge i_mclk);
      i_enh_scan_en <= 1'b1;
      i_prog_status <= 1'b1;
      i_prog_error <= 1'b1;
      tick(1);
      chk("enh_out", o_third_port_pins, 8'h5c);
      @(posedge i_mclk);
      i_enh_scan_en <= 1'b0;
      i_prog_status <= 1'b0;
      i_rdy_busy_en <= 1'b1;
      i_flash_ready <= 1'b1;
      tick(1);
      chk("rdy_out", o_third_port_pins, 8'h4c);
      @(posedge i_mclk);
      i_scan_en <= 1'b0;
      i_rdy_busy_en <= 1'b0;
      tick(1);
      chk("scan_off", {5'h00, o_scan_tms, o_scan_tck, o_scan_tdi}, 8'h00);
   endtask : t_scan
   task automatic t_od;
      @(posedge i_mclk);
      i_third_dir_val <= 8'h0f;
      i_third_open_drain <= 8'hff;
      tick(1);
      chk("od_out", o_third_port_pins, 8'h00);
      chk("od_oe", o_third_port_pins_oe, 8'hf0);
      @(posedge i_mclk);
      i_third_open_drain <= 8'h00;
      tick(1);
      chk("pp_oe", o_third_port_pins_oe, 8'hff);
   endtask : t_od
   task automatic t_fourth;
      @(posedge i_mclk);
      i_pld_shared_clock_in_en <= 1'b1;
      i_flash_cs_en <= 1'b1;
      i_fourth_port_pins <= 3'h2;
      tick(1);
      chk("clk_hi", {7'h00, o_pld_shared_clock_in}, 8'h01);
      chk("fl_on", {7'h00, o_flash_enable}, 8'h01);
      @(posedge i_mclk);
      i_fourth_port_pins <= 3'h4;
      tick(1);
      chk("clk_lo", {7'h00, o_pld_shared_clock_in}, 8'h00);
      chk("fl_off", {7'h00, o_flash_enable}, 8'h00);
      @(posedge i_mclk);
      i_flash_cs_en <= 1'b0;
      tick(1);
      chk("fl_free", {7'h00, o_flash_enable}, 8'h01);
   endtask : t_fourth
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict
   // main sequence
   initial begin
      {i_reset_n, i_scan_en, i_enh_scan_en, i_rdy_busy_en, i_pld_shared_clock_in_en, i_flash_cs_en, i_core_rd_oe} = '0;
      {i_scan_tdo, i_prog_status, i_prog_error, i_flash_ready, m_req, m_wr, m_wdata, i_core_rd_data} = '0;
      {i_second_dir_val, i_third_dir_val} = {8'h5a, 8'h96};
      {i_output_cell_group_one, i_output_cell_group_two} = {8'hc3, 8'h3c};
      {i_second_dir_oe, i_third_dir_oe, i_cell_oe_second, i_cell_oe_third} = {8'hff, 8'hff, 8'h0f, 8'hf0};
      {i_second_port_pins, i_third_port_pins, i_third_open_drain, i_second_slew} = '0;
      {i_fourth_dir_val, i_fourth_dir_oe, i_chip_sel, i_fourth_port_pins} = {3'h5, 3'h7, 3'h3, 3'h0};
      set_fn(FN_DIRECT_IO);
      tick(20);
      chk("rst_strobe", {7'h00, o_read_strobe}, 8'h01);
      chk("rst_bsel", {7'h00, o_byte_mem_select}, 8'h01);
      chk("rst_flash", {7'h00, o_flash_enable}, 8'h00);
      chk("rst_oe", o_third_port_pins_oe, 8'h00);
      @(posedge i_mclk);
      i_reset_n <= 1'b1;
      tick(1);
      t_data();
      t_funcs();
      t_read();
      t_slew();
      t_scan();
      t_od();
      t_fourth();
      give_verdict();
   end
endmodule : port_pin_function_mux_bench
